// File: rtl/usb_port_irq_enable.sv
// Port interrupt enable registers of a dual-role USB controller.
// Assumes event pulses and role levels come from logic on this clock,
// and an APB master on the register side.
//
// Function
// [RULE1] Port0 bit15 gates overcurrent onto interrupt.
// [RULE2] Port0 bit14 gates bus change onto interrupt.
// [RULE3] Port0 bit12 gates detach, only in host.
// [RULE4] Port0 bit11 gates attach onto interrupt.
// [RULE5] Port0 bit6 gates frame end error.
// [RULE6] Port0 bit5 gates setup transaction error.
// [RULE7] Port0 bit4 gates setup transaction complete.
// [RULE8] Port1 bit15 gates overcurrent onto interrupt.
// [RULE9] Port1 bit14 gates bus change onto interrupt.
// [RULE10] Port1 bit12 gates detach, only in host.
// [RULE11] Port1 bit11 gates attach onto interrupt.
// [RULE12] Port1 bit6 gates frame end error.
// [RULE13] Software writes zero to unassigned bits.
// [RULE14] Port0 enables except overcurrent: host-only writes.
// [RULE15] Port0 overcurrent enable writable in host or A-device.
// [RULE16] Port1 enables writable only in host role.
// [RULE17] Enables software read/write, hardware never modifies.
// [RULE18] Enabled pending cause asserts interrupt output.
// [RULE19] Status flags set regardless of enable.
// [RULE20] Enabling an already set flag asserts immediately.
// [RULE21] All enables read zero after reset.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module usb_port_irq_enable #(
    parameter int ADDR_WIDTH = 12
) (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_WIDTH-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  hostRole,
    input  wire logic                  otgADevice,
    input  wire logic [1:0]            overcurrentEvent,
    input  wire logic [1:0]            busChangeEvent,
    input  wire logic [1:0]            detachEvent,
    input  wire logic [1:0]            attachEvent,
    input  wire logic [1:0]            frameEndErrorEvent,
    input  wire logic                  setupErrorEvent,
    input  wire logic                  setupDoneEvent,
    output logic                       irqN
);
    import usb_irq_pkg::*;

    // ****
    // State
    // ****

    // All registered state of the top level, kept in one place.
    typedef struct packed
    {
        logic [15:0] port0IrqEnable; // Port 0 enable register.
        logic [15:0] port1IrqEnable; // Port 1 enable register.
        logic [31:0] readData;       // Registered read data.
        logic        ready;          // Registered APB ready.
        logic        slaveError;     // Registered APB error.
    } state_t;

    state_t state;      // Registered state.
    state_t next_state; // Next state.

    // ****
    // Address decode
    // ****

    logic        hitEnable0; // Access hits the port 0 enable register.
    logic        hitEnable1; // Access hits the port 1 enable register.
    logic        hitStatus0; // Access hits the port 0 status register.
    logic        hitStatus1; // Access hits the port 1 status register.
    logic        mapped;     // Access hits any register.
    logic        accessWait; // Access phase before ready is raised.
    logic        accessDone; // Access phase at the completing edge.
    logic        writeDone;  // Write takes effect at this edge.
    logic [15:0] laneMask;   // Byte lanes enabled by the strobes.
    logic [15:0] writeData;  // Low half of the write data.

    // Decode the full address so aliases do not silently hit registers.
    always_comb
    begin
        hitEnable0 = (paddr == ADDR_WIDTH'(PORT0_IRQ_ENABLE_ADDR));
        hitEnable1 = (paddr == ADDR_WIDTH'(PORT1_IRQ_ENABLE_ADDR));
        hitStatus0 = (paddr == ADDR_WIDTH'(PORT0_IRQ_STATUS_ADDR));
        hitStatus1 = (paddr == ADDR_WIDTH'(PORT1_IRQ_STATUS_ADDR));
        mapped     = hitEnable0 | hitEnable1 | hitStatus0 | hitStatus1;
    end

    // Phase tracking: one wait cycle, then ready for a single cycle.
    always_comb
    begin
        accessWait = psel & penable & ~state.ready;
        accessDone = psel & penable & state.ready;
        writeDone  = accessDone & pwrite & ~state.slaveError;
        laneMask   = {{8{pstrb[1]}}, {8{pstrb[0]}}};
        writeData  = pwdata[15:0];
    end

    // ****
    // Role-dependent write permission
    // ****

    logic [15:0] writable0; // Port 0 bits software may change now.
    logic [15:0] writable1; // Port 1 bits software may change now.

    // Writes outside the permitted role are dropped silently, so a
    // driver that keeps to the role rules never sees a difference.
    always_comb
    begin
        if (hostRole)
        begin
            writable0 = PORT0_IMPL_MASK; // see [RULE14]
        end
        else if (otgADevice)
        begin
            writable0 = OTG_A_WRITE_MASK; // see [RULE15]
        end
        else
        begin
            writable0 = 16'h0000; // see [RULE14]
        end
        // Unassigned bits are never stored, whatever software writes.
        writable0 = writable0 & PORT0_IMPL_MASK & laneMask; // see [RULE13]
        if (hostRole)
        begin
            writable1 = PORT1_IMPL_MASK & laneMask; // see [RULE16]
        end
        else
        begin
            writable1 = 16'h0000; // see [RULE16]
        end
    end

    // ****
    // Status flags
    // ****

    logic [15:0] set0;     // Port 0 event pulses in field layout.
    logic [15:0] set1;     // Port 1 event pulses in field layout.
    logic [15:0] clear0;   // Port 0 write-one-to-clear vector.
    logic [15:0] clear1;   // Port 1 write-one-to-clear vector.
    logic [15:0] status0;  // Port 0 sticky flags.
    logic [15:0] status1;  // Port 1 sticky flags.

    // Events are latched whatever the enables say, so software can
    // poll a cause it chose not to be interrupted by.
    always_comb
    begin
        set0 = 16'h0000;
        set1 = 16'h0000;
        set0[OVERCURRENT_BIT] = overcurrentEvent[0]; // see [RULE19]
        set0[BUS_CHANGE_BIT]  = busChangeEvent[0];
        set0[DETACH_BIT]      = detachEvent[0];
        set0[ATTACH_BIT]      = attachEvent[0];
        set0[FRAME_END_BIT]   = frameEndErrorEvent[0];
        set0[SETUP_ERROR_BIT] = setupErrorEvent;
        set0[SETUP_DONE_BIT]  = setupDoneEvent;
        set1[OVERCURRENT_BIT] = overcurrentEvent[1]; // see [RULE19]
        set1[BUS_CHANGE_BIT]  = busChangeEvent[1];
        set1[DETACH_BIT]      = detachEvent[1];
        set1[ATTACH_BIT]      = attachEvent[1];
        set1[FRAME_END_BIT]   = frameEndErrorEvent[1];
    end

    // A one written to a status bit clears it at the completing edge.
    always_comb
    begin
        clear0 = 16'h0000;
        clear1 = 16'h0000;
        if (writeDone && hitStatus0)
        begin
            clear0 = writeData & laneMask & PORT0_IMPL_MASK;
        end
        if (writeDone && hitStatus1)
        begin
            clear1 = writeData & laneMask & PORT1_IMPL_MASK;
        end
    end

    // Port 0 flags.
    sticky_status #(
        .WIDTH     (16)
    ) port0Flags (
        .clock     (clock),
        .rst       (rst),
        .setBits   (set0),
        .clearBits (clear0),
        .flags     (status0)
    );

    // Port 1 flags.
    sticky_status #(
        .WIDTH     (16)
    ) port1Flags (
        .clock     (clock),
        .rst       (rst),
        .setBits   (set1),
        .clearBits (clear1),
        .flags     (status1)
    );

    // ****
    // Interrupt gating
    // ****

    logic [15:0] gate0; // Port 0 enables as applied to the output.
    logic [15:0] gate1; // Port 1 enables as applied to the output.

    // Each enable passes its cause; detach counts only in host role.
    // The stored enable bit is left alone when the role changes.
    always_comb
    begin
        gate0 = 16'h0000;
        gate1 = 16'h0000;
        gate0[OVERCURRENT_BIT] = state.port0IrqEnable[OVERCURRENT_BIT]; // see [RULE1]
        gate0[BUS_CHANGE_BIT]  = state.port0IrqEnable[BUS_CHANGE_BIT]; // see [RULE2]
        gate0[DETACH_BIT]      = state.port0IrqEnable[DETACH_BIT] & hostRole; // see [RULE3]
        gate0[ATTACH_BIT]      = state.port0IrqEnable[ATTACH_BIT]; // see [RULE4]
        gate0[FRAME_END_BIT]   = state.port0IrqEnable[FRAME_END_BIT]; // see [RULE5]
        gate0[SETUP_ERROR_BIT] = state.port0IrqEnable[SETUP_ERROR_BIT]; // see [RULE6]
        gate0[SETUP_DONE_BIT]  = state.port0IrqEnable[SETUP_DONE_BIT]; // see [RULE7]
        gate1[OVERCURRENT_BIT] = state.port1IrqEnable[OVERCURRENT_BIT]; // see [RULE8]
        gate1[BUS_CHANGE_BIT]  = state.port1IrqEnable[BUS_CHANGE_BIT]; // see [RULE9]
        gate1[DETACH_BIT]      = state.port1IrqEnable[DETACH_BIT] & hostRole; // see [RULE10]
        gate1[ATTACH_BIT]      = state.port1IrqEnable[ATTACH_BIT]; // see [RULE11]
        gate1[FRAME_END_BIT]   = state.port1IrqEnable[FRAME_END_BIT]; // see [RULE12]
    end

    // The output follows flags and enables one edge later, so a newly
    // set enable on a pending flag asserts without waiting for a new event.
    irq_combine irqOut (
        .clock   (clock),
        .rst     (rst),
        .status0 (status0),
        .enable0 (gate0),
        .status1 (status1),
        .enable1 (gate1),
        .irqN    (irqN) // see [RULE18] see [RULE20]
    );

    // ****
    // Register file and bus answer
    // ****

    // Compute the next register and bus state.
    always_comb
    begin
        next_state = state;
        // Enables change only by software writes; hardware never does.
        if (writeDone && hitEnable0)
        begin
            next_state.port0IrqEnable = (state.port0IrqEnable & ~writable0)
                                      | (writeData & writable0); // see [RULE17]
        end
        if (writeDone && hitEnable1)
        begin
            next_state.port1IrqEnable = (state.port1IrqEnable & ~writable1)
                                      | (writeData & writable1); // see [RULE17]
        end
        // Ready is raised for exactly one cycle of each access phase.
        next_state.ready = accessWait;
        // Error accompanies ready for an unmapped address.
        next_state.slaveError = accessWait & ~mapped;
        // Read data is captured in the wait cycle and held until done.
        if (accessWait && !pwrite)
        begin
            if (hitEnable0)
            begin
                next_state.readData = {16'h0000, state.port0IrqEnable};
            end
            else if (hitEnable1)
            begin
                next_state.readData = {16'h0000, state.port1IrqEnable};
            end
            else if (hitStatus0)
            begin
                next_state.readData = {16'h0000, status0};
            end
            else if (hitStatus1)
            begin
                next_state.readData = {16'h0000, status1};
            end
            else
            begin
                next_state.readData = 32'h0000_0000;
            end
        end
        else if (accessDone)
        begin
            next_state.readData = 32'h0000_0000;
        end
    end

    // Register everything; reset leaves every enable cleared.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state.port0IrqEnable <= ENABLE_RESET; // see [RULE21]
            state.port1IrqEnable <= ENABLE_RESET; // see [RULE21]
            state.readData       <= 32'h0000_0000;
            state.ready          <= 1'b0;
            state.slaveError     <= 1'b0;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Bus outputs come straight from the state register.
    assign prdata  = state.readData;
    assign pready  = state.ready;
    assign pslverr = state.slaveError;
endmodule // usb_port_irq_enable

// File: rtl/usb_irq_pkg.sv
// Constants shared by the port interrupt enable block and its helpers.
// Assumes a 32-bit APB register bus and 16-bit wide enable registers.
package usb_irq_pkg;

    // ****
    // Register indices and byte addresses
    // ****

    // Printed register indices; the byte address is four times the index.
    localparam logic [11:0] PORT0_IRQ_ENABLE_IDX = 12'h032;
    localparam logic [11:0] PORT1_IRQ_ENABLE_IDX = 12'h034;
    localparam logic [11:0] PORT0_IRQ_STATUS_IDX = 12'h042;
    localparam logic [11:0] PORT1_IRQ_STATUS_IDX = 12'h044;
    localparam logic [11:0] PORT0_IRQ_ENABLE_ADDR = 12'h0C8;
    localparam logic [11:0] PORT1_IRQ_ENABLE_ADDR = 12'h0D0;
    localparam logic [11:0] PORT0_IRQ_STATUS_ADDR = 12'h108;
    localparam logic [11:0] PORT1_IRQ_STATUS_ADDR = 12'h110;

    // ****
    // Field positions, shared by enable and status registers
    // ****

    localparam int OVERCURRENT_BIT = 15;
    localparam int BUS_CHANGE_BIT  = 14;
    localparam int DETACH_BIT      = 12;
    localparam int ATTACH_BIT      = 11;
    localparam int FRAME_END_BIT   = 6;
    localparam int SETUP_ERROR_BIT = 5;
    localparam int SETUP_DONE_BIT  = 4;

    // Implemented bits of each register; all others read as zero.
    localparam logic [15:0] PORT0_IMPL_MASK = 16'hD870;
    localparam logic [15:0] PORT1_IMPL_MASK = 16'hD840;
    // Bits an OTG A-device may write outside host role.
    localparam logic [15:0] OTG_A_WRITE_MASK = 16'h8000;

    // ****
    // Reset values
    // ****

    localparam logic [15:0] ENABLE_RESET = 16'h0000;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic        IRQ_N_RESET  = 1'b1;

endpackage

// File: rtl/sticky_status.sv
// Sticky status flags: hardware events set bits, software clears them.
// Assumes set and clear vectors come from logic on the same clock.
`timescale 1ns/1ps
module sticky_status #(
    parameter int WIDTH = 16
) (
    input  wire logic                       clock,
    input  wire logic                       rst,
    input  wire logic [WIDTH-1:0]           setBits,
    input  wire logic [WIDTH-1:0]           clearBits,
    output logic      [WIDTH-1:0]           flags
);
    import usb_irq_pkg::*;

    // All state of this module.
    typedef struct packed
    {
        logic [WIDTH-1:0] flags; // Latched event flags.
    } state_t;

    state_t state;      // Registered state.
    state_t next_state; // Next state.

    // A set in the same cycle as a clear wins, so no event is lost.
    always_comb
    begin
        next_state = state;
        next_state.flags = (state.flags & ~clearBits) | setBits;
    end

    // Flags clear on reset and otherwise follow the computed next value.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state.flags <= WIDTH'(STATUS_RESET);
        end
        else
        begin
            state <= next_state;
        end
    end

    assign flags = state.flags;
endmodule // sticky_status

// File: rtl/irq_combine.sv
// Combines gated status of both ports onto one active-low interrupt line.
// Assumes enables are already qualified by role where needed.
`timescale 1ns/1ps
module irq_combine (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [15:0] status0,
    input  wire logic [15:0] enable0,
    input  wire logic [15:0] status1,
    input  wire logic [15:0] enable1,
    output logic             irqN
);
    import usb_irq_pkg::*;

    // All state of this module.
    typedef struct packed
    {
        logic irqN; // Registered interrupt line, low when asserted.
    } state_t;

    state_t state;      // Registered state.
    state_t next_state; // Next state.

    // Any pending flag whose enable is set pulls the line low.
    always_comb
    begin
        next_state = state;
        next_state.irqN = ~|((status0 & enable0) | (status1 & enable1));
    end

    // The line idles high through reset so no spurious request is seen.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state.irqN <= IRQ_N_RESET;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign irqN = state.irqN;
endmodule // irq_combine

// File: test/usb_port_irq_checker.sv
// Concurrent checks on the port interrupt enable block.
// Assumes it is bound to the block top and sees only its ports.
`timescale 1ns/1ps
module usb_port_irq_checker
    import usb_irq_pkg::*;
#(
    parameter int ADDR_WIDTH = 12
) (
    input wire logic                  clock,
    input wire logic                  rst,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [3:0]            pstrb,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic                  hostRole,
    input wire logic                  otgADevice,
    input wire logic [1:0]            attachEvent,
    input wire logic                  irqN
);
    // ****
    // Helper logic
    // ****
    logic en11;    // Shadow of the port0 attach enable.
    logic everSet; // Set once any nonzero word was written.
    logic wrDone;  // A write completes at this edge.
    logic mapped;  // The address hits one of the four registers.
    assign wrDone = psel && penable && pready && pwrite;
    assign mapped = paddr inside {PORT0_IRQ_ENABLE_ADDR, PORT1_IRQ_ENABLE_ADDR,
                                  PORT0_IRQ_STATUS_ADDR, PORT1_IRQ_STATUS_ADDR};

    // The shadow follows only host-role writes of the upper lane.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            en11    <= 1'b0;
            everSet <= 1'b0;
        end
        else if (wrDone)
        begin
            if (paddr == PORT0_IRQ_ENABLE_ADDR && hostRole && pstrb[1])
                en11 <= pwdata[11];
            if (pwdata[15:0] != 16'h0000)
                everSet <= 1'b1;
        end
    end

    // ****
    // Properties
    // ****
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready missing after first access cycle");
    a_reset_idle: assert property (disable iff (1'b0) rst |=> irqN && !pready)
        else $error("outputs not idle after reset");
    a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    a_port0_bits: assert property (pready && !pwrite && paddr == PORT0_IRQ_ENABLE_ADDR
        |-> (prdata[15:0] & ~PORT0_IMPL_MASK) == 16'h0000)
        else $error("port0 unassigned bit reads one");
    a_port1_bits: assert property (pready && !pwrite && paddr == PORT1_IRQ_ENABLE_ADDR
        |-> (prdata[15:0] & ~PORT1_IMPL_MASK) == 16'h0000)
        else $error("port1 unassigned bit reads one");
    a_unmapped_err: assert property (pready |-> pslverr == !mapped)
        else $error("error response wrong for address");
    a_attach_irq: assert property (attachEvent[0] && en11 && !psel |-> ##2 !irqN)
        else $error("enabled attach did not assert interrupt");
    a_quiet_start: assert property (!everSet |-> irqN)
        else $error("interrupt before any enable");

    c_error: cover property (pready && pslverr);
    c_irq: cover property ($fell(irqN));
    c_otg_write: cover property (wrDone && otgADevice && !hostRole);
endmodule // usb_port_irq_checker

// File: test/irq_host_model.sv
// Processor side model that services the active-low interrupt line.
// Assumes irqN comes from the block on the same clock.
`timescale 1ns/1ps
module irq_host_model (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic irqN,
    output int        served
);
    logic lastN; // Line level one cycle ago.

    // Each falling edge is one interrupt taken by the processor.
    always_ff @(posedge clock)
    begin
        lastN <= irqN;
        if (rst)
            served <= 0;
        else if (lastN && !irqN)
            served <= served + 1;
    end
endmodule // irq_host_model

// File: test/test_usb_port_irq_enable.sv
// Self-checking bench for the port interrupt enable block.
// Assumes package, block, checker and host model are compiled first.
`timescale 1ns/1ps
module test_usb_port_irq_enable;
    import usb_irq_pkg::*;
    logic        clock, rst, psel, penable, pwrite, pready, pslverr, irqN, rerr;
    logic        hostRole, otgADevice, setupErrorEvent, setupDoneEvent;
    logic [1:0]  overcurrentEvent, busChangeEvent, detachEvent, attachEvent, frameEndErrorEvent;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0]  pstrb;
    int          served, n_fail, n_compared, cycles;
    int          bitPos [12] = '{15, 14, 12, 11, 6, 5, 4, 15, 14, 12, 11, 6};

    usb_port_irq_enable uut (
        .clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .hostRole, .otgADevice, .overcurrentEvent, .busChangeEvent, .detachEvent,
        .attachEvent, .frameEndErrorEvent, .setupErrorEvent, .setupDoneEvent, .irqN
    );
    irq_host_model host (.clock, .rst, .irqN, .served);

    always #5 clock = ~clock;

    // A hang is cut short well beyond the expected run of under 1500 cycles.
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            n_fail++;
            $display("Timeout after %0d cycles", cycles);
            report_and_stop;
        end
    end

    // ****
    // Bus and compare tasks
    // ****
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One APB transfer; an idle cycle follows so no signal is driven twice at once.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [15:0] d,
                        input logic [3:0] s);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        pstrb <= s;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
            @(posedge clock);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        xfer(1'b1, a, d, 4'hF);
    endtask

    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 16'h0000, 4'h0);
        chk(nm, e, rdat);
    endtask

    // One-cycle pulse on the event input of cause k; ports split at k = 7.
    task automatic pulse(input int k);
        int b;
        b = k / 7;
        case (bitPos[k])
            15: overcurrentEvent[b] <= 1'b1;
            14: busChangeEvent[b] <= 1'b1;
            12: detachEvent[b] <= 1'b1;
            11: attachEvent[b] <= 1'b1;
            6: frameEndErrorEvent[b] <= 1'b1;
            5: setupErrorEvent <= 1'b1;
            default: setupDoneEvent <= 1'b1;
        endcase
        @(posedge clock);
        {overcurrentEvent, busChangeEvent, detachEvent, attachEvent} <= 8'h00;
        {frameEndErrorEvent, setupErrorEvent, setupDoneEvent} <= 4'h0;
    endtask

    // ****
    // Scenarios
    // ****
    task automatic t_reset;
        rdchk("port0 enable", PORT0_IRQ_ENABLE_ADDR, 32'h0);
        rdchk("port1 enable", PORT1_IRQ_ENABLE_ADDR, 32'h0);
        chk("irqN idle", 32'h1, {31'h0, irqN});
        $display("t_reset done");
    endtask

    // Ones to unassigned bits on purpose; lanes without strobe stay put.
    task automatic t_rw;
        wr(PORT0_IRQ_ENABLE_ADDR, 16'hFFFF);
        rdchk("port0 all", PORT0_IRQ_ENABLE_ADDR, 32'h0000D870);
        wr(PORT1_IRQ_ENABLE_ADDR, 16'hFFFF);
        rdchk("port1 all", PORT1_IRQ_ENABLE_ADDR, 32'h0000D840);
        wr(PORT0_IRQ_ENABLE_ADDR, 16'h0000);
        wr(PORT1_IRQ_ENABLE_ADDR, 16'h0000);
        xfer(1'b1, PORT0_IRQ_ENABLE_ADDR, 16'hFFFF, 4'h1);
        rdchk("low lane", PORT0_IRQ_ENABLE_ADDR, 32'h00000070);
        wr(PORT0_IRQ_ENABLE_ADDR, 16'h0000);
        xfer(1'b0, 12'h0CC, 16'h0000, 4'h0);
        chk("unmapped error", 32'h1, {31'h0, rerr});
        chk("unmapped data", 32'h0, rdat);
        $display("t_rw done");
    endtask

    // Every cause: flag set while masked, late enable, clear, enabled event.
    task automatic t_gate;
        logic [11:0] a, sa;
        logic [15:0] m;
        int          s0;
        s0 = served;
        for (int k = 0; k < 12; k++)
        begin
            a = (k < 7) ? PORT0_IRQ_ENABLE_ADDR : PORT1_IRQ_ENABLE_ADDR;
            sa = (k < 7) ? PORT0_IRQ_STATUS_ADDR : PORT1_IRQ_STATUS_ADDR;
            m = 16'h0001 << bitPos[k];
            pulse(k);
            repeat (3) @(posedge clock);
            chk("irqN masked", 32'h1, {31'h0, irqN}); // to
            rdchk("status", sa, {16'h0000, m});
            wr(a, m);
            @(posedge clock);
            chk("irqN on enable", 32'h0, {31'h0, irqN});
            wr(sa, m);
            @(posedge clock);
            chk("irqN cleared", 32'h1, {31'h0, irqN});
            pulse(k);
            repeat (3) @(posedge clock);
            chk("irqN on event", 32'h0, {31'h0, irqN}); // to
            wr(a, 16'h0000);
            @(posedge clock);
            chk("irqN disabled", 32'h1, {31'h0, irqN}); // to
            wr(sa, m);
        end
        chk("served", 32'd24, 32'(served - s0));
        $display("t_gate done");
    endtask

    // Writes outside host role on purpose; detach gating follows the role.
    task automatic t_roles;
        hostRole <= 1'b0;
        @(posedge clock);
        wr(PORT0_IRQ_ENABLE_ADDR, 16'hFFFF);
        rdchk("port0 peripheral", PORT0_IRQ_ENABLE_ADDR, 32'h0);
        wr(PORT1_IRQ_ENABLE_ADDR, 16'hFFFF);
        rdchk("port1 peripheral", PORT1_IRQ_ENABLE_ADDR, 32'h0);
        otgADevice <= 1'b1;
        wr(PORT0_IRQ_ENABLE_ADDR, 16'hFFFF);
        rdchk("port0 a-device", PORT0_IRQ_ENABLE_ADDR, 32'h00008000);
        wr(PORT0_IRQ_ENABLE_ADDR, 16'h0000);
        otgADevice <= 1'b0;
        hostRole <= 1'b1;
        wr(PORT0_IRQ_ENABLE_ADDR, 16'h1000);
        wr(PORT1_IRQ_ENABLE_ADDR, 16'h1000);
        hostRole <= 1'b0;
        pulse(2);
        @(posedge clock);
        pulse(9);
        repeat (3) @(posedge clock);
        chk("detach outside host", 32'h1, {31'h0, irqN});
        rdchk("detach kept", PORT1_IRQ_ENABLE_ADDR, 32'h00001000);
        hostRole <= 1'b1;
        repeat (2) @(posedge clock);
        chk("detach in host", 32'h0, {31'h0, irqN});
        wr(PORT0_IRQ_STATUS_ADDR, 16'h1000);
        wr(PORT1_IRQ_STATUS_ADDR, 16'h1000);
        wr(PORT0_IRQ_ENABLE_ADDR, 16'h0000);
        wr(PORT1_IRQ_ENABLE_ADDR, 16'h0000);
        $display("t_roles done");
    endtask

    task automatic report_and_stop;
        $display("Compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        {clock, psel, penable, pwrite, otgADevice, setupErrorEvent, setupDoneEvent} = 7'h00;
        {overcurrentEvent, busChangeEvent, detachEvent, attachEvent, frameEndErrorEvent} = 10'h000;
        {paddr, pwdata, pstrb} = 48'h0;
        rst = 1'b1;
        hostRole = 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_reset;
        t_rw;
        t_gate;
        t_roles;
        report_and_stop;
    end
endmodule // test_usb_port_irq_enable

bind usb_port_irq_enable usb_port_irq_checker #(.ADDR_WIDTH(ADDR_WIDTH)) checker_i (
    .clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .hostRole, .otgADevice, .attachEvent, .irqN
);
